// file: inc/bsc_pkg.sv
// constants for the boundary scan cell chain
`default_nettype none
package bsc_pkg;
  // chain geometry
  localparam int CHAIN_LEN = 184;
  localparam int CHAIN_MSB = 183;
  // fixed output cells without a direction control
  localparam int POS_RST = 0;
  localparam int POS_IRQ_PEND = 1;
  // output cells on the misc enable
  localparam int POS_CACHE_INH = 2;
  localparam int POS_ATTR0 = 3;
  localparam int POS_ATTR1 = 4;
  // transfer type pairs, output then input
  localparam int POS_TT_FIRST = 5;
  localparam int TT_W = 2;
  // address pairs, output then input, bits 10 to 31
  localparam int POS_ADDR_FIRST = 9;
  localparam int POS_ADDR_LAST = 52;
  localparam int ADDR_W = 22;
  // data output cells, bits 0 to 20
  localparam int POS_DATA_FIRST = 53;
  localparam int POS_DATA_LAST = 73;
  localparam int DATA_W = 21;
  localparam int UPA_W = 2;
  // direction control cells
  localparam int POS_AB = 150;
  localparam int POS_DB = 151;
  localparam int POS_IO2 = 154;
  localparam int POS_IO1 = 155;
  localparam int POS_IO0 = 156;
  // bit order of the synchronised tap and instruction lines
  localparam int CT_CAPTURE = 0;
  localparam int CT_SHIFT = 1;
  localparam int CT_UPDATE = 2;
  localparam int CT_TLR = 3;
  localparam int CT_EXTEST = 4;
  localparam int CT_SAMPLE = 5;
  localparam int CT_W = 6;
  // register port
  localparam int RA_W = 8;
  localparam int RD_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHAIN0 = 8'h08;
  localparam int CHAIN_WORDS = 6;
  localparam int CHAIN_PAD = 8;
  localparam logic CTRL_PORT_EN_RESET = 1'h1;
  // status field positions
  localparam int ST_AB = 0;
  localparam int ST_DB = 1;
  localparam int ST_IO2 = 2;
  localparam int ST_IO1 = 3;
  localparam int ST_IO0 = 4;
  localparam int ST_TEST = 5;
  localparam int ST_SEL = 6;
  localparam int ST_TDO = 7;
  localparam int ST_PORT_EN = 8;
endpackage : bsc_pkg
`default_nettype wire

// file: rtl/bsc_chain.sv
// boundary scan cell chain with pin muxing and register port
// How it works
// - chain of 184 cells, serial between tdi and tdo
// - cell zero leaves first, cell 183 last
// - cells drive outputs, sample inputs, set direction
// - cells for all pins plus direction controls
// - every cell is output, input or control kind
// - output cells capture internal output latch value
// - each bidirectional pin owns output and input cell
// - five shared control cells govern bidirectional pins
// - control cell one enables the pin driver
// - control cells capture their own present value
// - test logic reset clears all control cells
// - address, data, third enables at 150,151,154
// - fourth enable at 155, misc enable 156
// - cells 0..4 reset, irq pending, cache inhibit, attributes
// - transfer type pairs, then address 10..31 pairs
// - cells 53..73 hold data 0..20 outputs
// - address, data, misc pins follow their enables
// - three-state outputs drive only, bidirectionals both ways
// - extest selects chain, resets core, keeps clock alive
// - preload shifts and updates before extest
//
// The register offsets and the strobed register port were left to the implementer.
`default_nettype none
module bsc_chain (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_tlr,
  input wire logic instr_extest,
  input wire logic instr_sample,
  output logic tdo,
  input wire logic sys_rst_out,
  input wire logic sys_irq_pend_out,
  input wire logic sys_cache_inh_out,
  input wire logic [bsc_pkg::UPA_W-1:0] sys_upa_out,
  input wire logic [bsc_pkg::TT_W-1:0] sys_tt_out,
  input wire logic [bsc_pkg::ADDR_W-1:0] sys_addr_out,
  input wire logic [bsc_pkg::DATA_W-1:0] sys_data_out,
  input wire logic sys_addr_oe,
  input wire logic sys_data_oe,
  input wire logic sys_misc_oe,
  input wire logic [bsc_pkg::TT_W-1:0] tt_in,
  input wire logic [bsc_pkg::ADDR_W-1:0] addr_in,
  output logic reset_out_pin,
  output logic interrupt_pending_pin,
  output logic cache_inhibit_out_pin,
  output logic user_page_attr_bit_zero,
  output logic user_page_attr_bit_one,
  output logic [bsc_pkg::TT_W-1:0] transfer_type_out,
  output logic [bsc_pkg::ADDR_W-1:0] addr_out,
  output logic [bsc_pkg::DATA_W-1:0] data_out,
  output logic misc_bus_oe,
  output logic addr_oe,
  output logic data_oe,
  output logic aux_enable_one,
  output logic aux_enable_two,
  output logic sys_reset_req,
  output logic keepalive_run,
  input wire logic [bsc_pkg::RA_W-1:0] reg_addr,
  input wire logic [bsc_pkg::RD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bsc_pkg::RD_W-1:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [2:0] tck_s;
    logic tdi_s1;
    logic tdi_s2;
    logic [bsc_pkg::CT_W-1:0] ctl_s1;
    logic [bsc_pkg::CT_W-1:0] ctl_s2;
    logic [bsc_pkg::ADDR_W+bsc_pkg::TT_W-1:0] pin_s1;
    logic [bsc_pkg::ADDR_W+bsc_pkg::TT_W-1:0] pin_s2;
    logic [bsc_pkg::CHAIN_MSB:0] shift;
    logic [bsc_pkg::CHAIN_MSB:0] upd;
    logic tdo;
    logic port_en;
    logic rst_out;
    logic irq_pend;
    logic cache_inh;
    logic [bsc_pkg::UPA_W-1:0] upa;
    logic [bsc_pkg::TT_W-1:0] tt_out;
    logic [bsc_pkg::ADDR_W-1:0] addr_out;
    logic [bsc_pkg::DATA_W-1:0] data_out;
    logic misc_oe;
    logic addr_oe;
    logic data_oe;
    logic io1;
    logic io2;
    logic core_rst;
    logic [bsc_pkg::RD_W-1:0] rdata;
  } bsc_state_t;

  bsc_state_t r;
  bsc_state_t next_r;

  // chain position of the k-th cell of an output/input pair group
  function automatic int pair_pos(input int base, input int k, input int is_in);
    pair_pos = base + 2 * k + is_in;
  endfunction : pair_pos

  logic selected;
  logic test_mode;
  logic tck_rise;
  logic tck_fall;
  logic [bsc_pkg::CHAIN_MSB:0] cap;
  logic [bsc_pkg::CHAIN_WORDS*bsc_pkg::RD_W-1:0] chain_words;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    // two-stage synchronisers, third tck stage only for edge finding
    next_r.tck_s = {r.tck_s[1:0], tck};
    next_r.tdi_s1 = tdi;
    next_r.tdi_s2 = r.tdi_s1;
    next_r.ctl_s1 = {instr_sample, instr_extest, tap_tlr, tap_update_dr, tap_shift_dr,
                     tap_capture_dr};
    next_r.ctl_s2 = r.ctl_s1;
    next_r.pin_s1 = {addr_in, tt_in};
    next_r.pin_s2 = r.pin_s1;

    tck_rise = r.tck_s[1] & ~r.tck_s[2];
    tck_fall = ~r.tck_s[1] & r.tck_s[2];
    // chain reachable under extest or sample/preload
    selected = r.port_en & (r.ctl_s2[bsc_pkg::CT_EXTEST] | r.ctl_s2[bsc_pkg::CT_SAMPLE]);
    test_mode = r.ctl_s2[bsc_pkg::CT_EXTEST];

    // capture values; cells outside this map and control cells hold their latch
    cap = r.upd;
    cap[bsc_pkg::POS_RST] = sys_rst_out;
    cap[bsc_pkg::POS_IRQ_PEND] = sys_irq_pend_out;
    cap[bsc_pkg::POS_CACHE_INH] = sys_cache_inh_out;
    cap[bsc_pkg::POS_ATTR0] = sys_upa_out[0];
    cap[bsc_pkg::POS_ATTR1] = sys_upa_out[1];
    // output cells latch value, input cells pin level
    for (int k = 0; k < bsc_pkg::TT_W; k++) begin
      cap[pair_pos(bsc_pkg::POS_TT_FIRST, k, 0)] = sys_tt_out[k];
      cap[pair_pos(bsc_pkg::POS_TT_FIRST, k, 1)] = r.pin_s2[k];
    end
    for (int k = 0; k < bsc_pkg::ADDR_W; k++) begin
      cap[pair_pos(bsc_pkg::POS_ADDR_FIRST, k, 0)] = sys_addr_out[k];
      cap[pair_pos(bsc_pkg::POS_ADDR_FIRST, k, 1)] = r.pin_s2[bsc_pkg::TT_W+k];
    end
    for (int k = 0; k < bsc_pkg::DATA_W; k++) begin
      cap[bsc_pkg::POS_DATA_FIRST+k] = sys_data_out[k];
    end

    // capture and shift on tck rise
    if (tck_rise && selected) begin
      if (r.ctl_s2[bsc_pkg::CT_CAPTURE]) begin
        next_r.shift = cap;
      end else if (r.ctl_s2[bsc_pkg::CT_SHIFT]) begin
        next_r.shift = {r.tdi_s2, r.shift[bsc_pkg::CHAIN_MSB:1]};
      end
    end
    // update and tdo on tck fall
    if (tck_fall && selected) begin
      next_r.tdo = r.shift[0];
      if (r.ctl_s2[bsc_pkg::CT_UPDATE]) begin
        next_r.upd = r.shift;
      end
    end
    // test logic reset clears the five control cells
    if (r.ctl_s2[bsc_pkg::CT_TLR]) begin
      next_r.upd[bsc_pkg::POS_AB] = 1'h0;
      next_r.upd[bsc_pkg::POS_DB] = 1'h0;
      next_r.upd[bsc_pkg::POS_IO2] = 1'h0;
      next_r.upd[bsc_pkg::POS_IO1] = 1'h0;
      next_r.upd[bsc_pkg::POS_IO0] = 1'h0;
      next_r.shift[bsc_pkg::POS_AB] = 1'h0;
      next_r.shift[bsc_pkg::POS_DB] = 1'h0;
      next_r.shift[bsc_pkg::POS_IO2] = 1'h0;
      next_r.shift[bsc_pkg::POS_IO1] = 1'h0;
      next_r.shift[bsc_pkg::POS_IO0] = 1'h0;
    end

    // pin drive: update latches under extest, core otherwise with the two aux enables held low
    next_r.core_rst = test_mode;
    if (test_mode) begin
      next_r.rst_out = r.upd[bsc_pkg::POS_RST];
      next_r.irq_pend = r.upd[bsc_pkg::POS_IRQ_PEND];
      next_r.cache_inh = r.upd[bsc_pkg::POS_CACHE_INH];
      next_r.upa = {r.upd[bsc_pkg::POS_ATTR1], r.upd[bsc_pkg::POS_ATTR0]};
      for (int k = 0; k < bsc_pkg::TT_W; k++) begin
        next_r.tt_out[k] = r.upd[pair_pos(bsc_pkg::POS_TT_FIRST, k, 0)];
      end
      for (int k = 0; k < bsc_pkg::ADDR_W; k++) begin
        next_r.addr_out[k] = r.upd[pair_pos(bsc_pkg::POS_ADDR_FIRST, k, 0)];
      end
      next_r.data_out = r.upd[bsc_pkg::POS_DATA_LAST:bsc_pkg::POS_DATA_FIRST];
      // one drives, zero floats the governed pins
      next_r.addr_oe = r.upd[bsc_pkg::POS_AB];
      next_r.data_oe = r.upd[bsc_pkg::POS_DB];
      next_r.misc_oe = r.upd[bsc_pkg::POS_IO0];
      next_r.io2 = r.upd[bsc_pkg::POS_IO2];
      next_r.io1 = r.upd[bsc_pkg::POS_IO1];
    end else begin
      next_r.rst_out = sys_rst_out;
      next_r.irq_pend = sys_irq_pend_out;
      next_r.cache_inh = sys_cache_inh_out;
      next_r.upa = sys_upa_out;
      next_r.tt_out = sys_tt_out;
      next_r.addr_out = sys_addr_out;
      next_r.data_out = sys_data_out;
      next_r.addr_oe = sys_addr_oe;
      next_r.data_oe = sys_data_oe;
      next_r.misc_oe = sys_misc_oe;
      next_r.io2 = 1'h0;
      next_r.io1 = 1'h0;
    end

    // register port: control write, one-cycle read data
    chain_words = {{bsc_pkg::CHAIN_PAD{1'h0}}, r.upd};
    if (reg_wr && reg_addr == bsc_pkg::REG_CTRL) begin
      next_r.port_en = reg_wdata[0];
    end
    next_r.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == bsc_pkg::REG_CTRL) begin
        next_r.rdata[0] = r.port_en;
      end else if (reg_addr == bsc_pkg::REG_STATUS) begin
        next_r.rdata[bsc_pkg::ST_AB] = r.upd[bsc_pkg::POS_AB];
        next_r.rdata[bsc_pkg::ST_DB] = r.upd[bsc_pkg::POS_DB];
        next_r.rdata[bsc_pkg::ST_IO2] = r.upd[bsc_pkg::POS_IO2];
        next_r.rdata[bsc_pkg::ST_IO1] = r.upd[bsc_pkg::POS_IO1];
        next_r.rdata[bsc_pkg::ST_IO0] = r.upd[bsc_pkg::POS_IO0];
        next_r.rdata[bsc_pkg::ST_TEST] = test_mode;
        next_r.rdata[bsc_pkg::ST_SEL] = selected;
        next_r.rdata[bsc_pkg::ST_TDO] = r.tdo;
        next_r.rdata[bsc_pkg::ST_PORT_EN] = r.port_en;
      end else begin
        for (int w = 0; w < bsc_pkg::CHAIN_WORDS; w++) begin
          if (reg_addr == bsc_pkg::REG_CHAIN0 + bsc_pkg::RA_W'(4 * w)) begin
            next_r.rdata = chain_words[w*bsc_pkg::RD_W +: bsc_pkg::RD_W];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // whole state, async reset to constants
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.port_en <= bsc_pkg::CTRL_PORT_EN_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign tdo = r.tdo;
  assign reset_out_pin = r.rst_out;
  assign interrupt_pending_pin = r.irq_pend;
  assign cache_inhibit_out_pin = r.cache_inh;
  assign user_page_attr_bit_zero = r.upa[0];
  assign user_page_attr_bit_one = r.upa[1];
  assign transfer_type_out = r.tt_out;
  assign addr_out = r.addr_out;
  assign data_out = r.data_out;
  assign misc_bus_oe = r.misc_oe;
  assign addr_oe = r.addr_oe;
  assign data_oe = r.data_oe;
  assign aux_enable_one = r.io1;
  assign aux_enable_two = r.io2;
  assign sys_reset_req = r.core_rst;
  assign keepalive_run = r.core_rst;
  assign reg_rdata = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_shift_order: assert property (
    tck_rise && selected && r.ctl_s2[bsc_pkg::CT_SHIFT] && !r.ctl_s2[bsc_pkg::CT_CAPTURE]
    && !r.ctl_s2[bsc_pkg::CT_TLR]
    |=> r.shift[bsc_pkg::CHAIN_MSB] == $past(r.tdi_s2) && r.shift[0] == $past(r.shift[1]))
    else $error("shift stage did not move one place toward tdo");

  a_capture_out_latch: assert property (
    tck_rise && selected && r.ctl_s2[bsc_pkg::CT_CAPTURE]
    |=> r.shift[bsc_pkg::POS_RST] == $past(sys_rst_out)
        && r.shift[bsc_pkg::POS_DATA_FIRST] == $past(sys_data_out[0]))
    else $error("output cell did not capture the internal latch");

  a_capture_ctl_self: assert property (
    tck_rise && selected && r.ctl_s2[bsc_pkg::CT_CAPTURE] && !r.ctl_s2[bsc_pkg::CT_TLR]
    |=> r.shift[bsc_pkg::POS_DB] == $past(r.upd[bsc_pkg::POS_DB]))
    else $error("control cell did not capture its own value");

  a_capture_addr_in: assert property (
    tck_rise && selected && r.ctl_s2[bsc_pkg::CT_CAPTURE]
    |=> r.shift[bsc_pkg::POS_ADDR_LAST] == $past(r.pin_s2[bsc_pkg::ADDR_W+bsc_pkg::TT_W-1]))
    else $error("address input cell did not sample the pin");

  a_tlr_clears_ctl: assert property (
    r.ctl_s2[bsc_pkg::CT_TLR]
    |=> !r.upd[bsc_pkg::POS_AB] && !r.upd[bsc_pkg::POS_DB] && !r.upd[bsc_pkg::POS_IO0]
        && !r.upd[bsc_pkg::POS_IO1] && !r.upd[bsc_pkg::POS_IO2])
    else $error("control cells not cleared by test logic reset");

  a_update_loads: assert property (
    tck_fall && selected && r.ctl_s2[bsc_pkg::CT_UPDATE] && !r.ctl_s2[bsc_pkg::CT_TLR]
    |=> r.upd == $past(r.shift))
    else $error("update latch did not load the shift stage");

  a_tdo_cell_zero: assert property (
    tck_fall && selected |=> r.tdo == $past(r.shift[0]))
    else $error("tdo does not present cell zero");

  a_addr_enable: assert property (
    test_mode |=> addr_oe == $past(r.upd[bsc_pkg::POS_AB])
                  && misc_bus_oe == $past(r.upd[bsc_pkg::POS_IO0]))
    else $error("bus enable does not follow its control cell");

  a_data_float: assert property (
    test_mode && !r.upd[bsc_pkg::POS_DB] |=> !data_oe)
    else $error("data pins driven with their control cell at zero");

  a_pair_drive: assert property (
    test_mode |=> addr_out[0] == $past(r.upd[bsc_pkg::POS_ADDR_FIRST])
                  && reset_out_pin == $past(r.upd[bsc_pkg::POS_RST]))
    else $error("pin not driven from its output cell");

  a_extest_reset: assert property (
    test_mode |=> sys_reset_req && keepalive_run)
    else $error("extest did not hold core reset and keep-alive");

  a_read_one_cycle: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data stood outside its cycle");

  c_preload_update: cover property (
    tck_fall && r.ctl_s2[bsc_pkg::CT_SAMPLE] && r.ctl_s2[bsc_pkg::CT_UPDATE] && selected);
  c_extest_drive: cover property (test_mode && r.upd[bsc_pkg::POS_AB] ##1 addr_oe);
  c_tlr_clear: cover property (r.ctl_s2[bsc_pkg::CT_TLR] && r.upd[bsc_pkg::POS_DB]);

endmodule : bsc_chain
`default_nettype wire

// file: sim/bsc_tester.sv
// external scan tester model driving the test port
`default_nettype none
module bsc_tester (
  output logic tck,
  output logic tdi,
  output logic cap_dr,
  output logic shift_dr,
  output logic upd_dr,
  output logic tlr,
  output logic extest,
  output logic sample,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // test clock stands low outside frames
  initial begin
    {tck, cap_dr, shift_dr, upd_dr, tlr, extest, sample} = '0;
    tdi = 1'b1;
  end
  // one test clock period, held 40 ns past the fall
  task automatic pulse();
    #80 tck = 1'b1;
    #80 tck = 1'b0;
    #40;
  endtask : pulse
  // instruction lines change only while the test clock is low
  task automatic instr(input logic e, input logic s);
    extest = e;
    sample = s;
    #100;
  endtask : instr
  // test logic reset held for a few hundred ns
  task automatic reset_tap();
    tlr = 1'b1;
    #400 tlr = 1'b0;
    #100;
  endtask : reset_tap
  // capture, shift all cells, update; dout[i] is the i-th bit out
  task automatic scan(input logic [183:0] din, output logic [183:0] dout);
    #3 cap_dr = 1'b1;
    pulse();
    cap_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < 184; i++) begin
      tdi = din[i];
      #79 dout[i] = tdo;
      #1 tck = 1'b1;
      #80 tck = 1'b0;
    end
    #40 shift_dr = 1'b0;
    tdi = ~tdi; // released line shows the inverse
    upd_dr = 1'b1;
    pulse();
    upd_dr = 1'b0;
  endtask : scan
endmodule : bsc_tester
`default_nettype wire

// file: sim/tb_top.sv
// self-checking testbench for the boundary scan cell chain
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wire tck, tdi, tdo, cap, sft, upd, tlr, ext, smp;
  logic rop, ipp, cip, up0, up1, moe, aoe, doe, ax1, ax2, srq, kar;
  logic [1:0] tto;
  logic [21:0] ao;
  logic [20:0] dp;
  logic [31:0] rdata;
  logic s_rst = 1'b1, s_ip = 1'b0, s_ci = 1'b1;
  logic s_aoe = 1'b1, s_doe = 1'b0, s_moe = 1'b1;
  logic [1:0] s_upa = 2'h2, s_tt = 2'h1, t_in = 2'h2;
  logic [21:0] s_ad = 22'h2A5A5C, a_in = 22'h15A3C3;
  logic [20:0] s_dt = 21'h1B3C5E;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [183:0] lat = '0, so;
  int bad_count = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  bsc_chain i_bsc_chain (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tdi(tdi),
    .tap_capture_dr(cap), .tap_shift_dr(sft), .tap_update_dr(upd), .tap_tlr(tlr),
    .instr_extest(ext), .instr_sample(smp), .tdo(tdo), .sys_rst_out(s_rst),
    .sys_irq_pend_out(s_ip), .sys_cache_inh_out(s_ci), .sys_upa_out(s_upa), .sys_tt_out(s_tt),
    .sys_addr_out(s_ad), .sys_data_out(s_dt), .sys_addr_oe(s_aoe), .sys_data_oe(s_doe),
    .sys_misc_oe(s_moe), .tt_in(t_in), .addr_in(a_in), .reset_out_pin(rop),
    .interrupt_pending_pin(ipp), .cache_inhibit_out_pin(cip), .user_page_attr_bit_zero(up0),
    .user_page_attr_bit_one(up1), .transfer_type_out(tto), .addr_out(ao), .data_out(dp),
    .misc_bus_oe(moe), .addr_oe(aoe), .data_oe(doe), .aux_enable_one(ax1),
    .aux_enable_two(ax2), .sys_reset_req(srq), .keepalive_run(kar), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  bsc_tester i_bsc_tester (.tck(tck), .tdi(tdi), .cap_dr(cap), .shift_dr(sft),
    .upd_dr(upd), .tlr(tlr), .extest(ext), .sample(smp), .tdo(tdo));
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #600000;
    bad_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // comparison, register access and expectation helpers
  task automatic chk(input string nm, input logic [183:0] seen, input logic [183:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask : rd_chk
  // all six update latch words against l
  task automatic chain_chk(input logic [183:0] l);
    for (int w = 0; w < 6; w++) begin
      rd_chk(8'(bsc_pkg::REG_CHAIN0 + 4 * w), 32'(l >> (32 * w)), "chain word");
    end
  endtask : chain_chk
  // pins gathered at their cell positions
  function automatic logic [183:0] pin_map();
    logic [183:0] v;
    v = '0;
    {v[4], v[3], v[2], v[1], v[0], v[7], v[5]} = {up1, up0, cip, ipp, rop, tto};
    for (int k = 0; k < 22; k++) v[9 + 2 * k] = ao[k];
    v[73:53] = dp;
    {v[156], v[155], v[154], v[151], v[150]} = {moe, ax1, ax2, doe, aoe};
    return v;
  endfunction : pin_map
  // core latches and enables at their cell positions, aux enables low
  function automatic logic [183:0] sys_map();
    logic [183:0] v;
    v = '0;
    {v[4:3], v[2], v[1], v[0], v[7], v[5]} = {s_upa, s_ci, s_ip, s_rst, s_tt};
    for (int k = 0; k < 22; k++) v[9 + 2 * k] = s_ad[k];
    v[73:53] = s_dt;
    {v[156], v[151], v[150]} = {s_moe, s_doe, s_aoe};
    return v;
  endfunction : sys_map
  function automatic logic [183:0] pins_of(input logic [183:0] l);
    logic [183:0] v;
    v = '0;
    for (int i = 0; i < 184; i++) begin
      if (i <= 5 || i == 7 || (i >= 9 && i <= 51 && i % 2 == 1) || (i >= 53 && i <= 73)
          || i == 150 || i == 151 || (i >= 154 && i <= 156)) v[i] = l[i];
    end
    return v;
  endfunction : pins_of
  // capture: output cells load core latches, input cells pins, others keep own
  function automatic logic [183:0] cap_exp(input logic [183:0] l);
    logic [183:0] v;
    v = l;
    {v[4:3], v[2], v[1], v[0]} = {s_upa, s_ci, s_ip, s_rst};
    {v[8], v[7], v[6], v[5]} = {t_in[1], s_tt[1], t_in[0], s_tt[0]};
    for (int k = 0; k < 22; k++) {v[10 + 2 * k], v[9 + 2 * k]} = {a_in[k], s_ad[k]};
    v[73:53] = s_dt;
    return v;
  endfunction : cap_exp
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk("pins after reset", pin_map(), sys_map());
    rd_chk(bsc_pkg::REG_CTRL, 32'h00000001, "ctrl");
    rd_chk(bsc_pkg::REG_STATUS, 32'h00000100, "status");
    rd_chk(8'h40, 32'h00000000, "unmapped");
    @(posedge core_clk);
    #1 chk("rdata idle", rdata, '0);
  endtask : t_reset
  task automatic t_preload();
    i_bsc_tester.instr(1'b0, 1'b1);
    i_bsc_tester.scan({23{8'hC5}}, so);
    chk("sample capture", so, cap_exp(lat));
    lat = {23{8'hC5}};
    chain_chk(lat);
    chk("preload pins", pin_map(), sys_map());
  endtask : t_preload
  task automatic t_extest();
    i_bsc_tester.instr(1'b1, 1'b0);
    repeat (8) @(posedge core_clk);
    chk("extest pins", pin_map(), pins_of(lat));
    chk("core reset and keepalive", {srq, kar}, 2'h3);
    rd_chk(bsc_pkg::REG_STATUS, {23'h0, 1'b1, lat[0], 2'h3, lat[156], lat[155], lat[154],
      lat[151], lat[150]}, "status");
    i_bsc_tester.scan(~lat, so);
    chk("extest capture", so, cap_exp(lat));
    lat = ~lat;
    repeat (8) @(posedge core_clk);
    chk("extest pins two", pin_map(), pins_of(lat));
  endtask : t_extest
  task automatic t_tlr();
    i_bsc_tester.reset_tap();
    {lat[156], lat[155], lat[154], lat[151], lat[150]} = '0;
    chk("pins after tlr", pin_map(), pins_of(lat));
    chain_chk(lat);
  endtask : t_tlr
  task automatic t_disabled();
    wr_reg(bsc_pkg::REG_CTRL, 32'h0);
    i_bsc_tester.scan({23{8'h3C}}, so);
    chk("tdo holds", so, {184{lat[0]}});
    chain_chk(lat);
    wr_reg(bsc_pkg::REG_CTRL, 32'h1);
    rd_chk(bsc_pkg::REG_CTRL, 32'h00000001, "ctrl back");
  endtask : t_disabled
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_reset();
    t_preload();
    t_extest();
    t_tlr();
    t_disabled();
    end_of_test();
  end
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
endmodule : tb_top
`default_nettype wire
